// >>> design/link_param_ctrl.sv
// Summary of operation
// - Interleaved mode merges cores, double sample rate
// - Interleaved input chosen by select, input_a preferred
// - Input selection applies only after calibration
// - Both-input interleave: own inputs, opposite phase
// - Dual-input interleave keeps single-channel link format
// - Interleave flag one single-channel, zero dual
// - R sets lane rate and PLL factor
// - K from written field, clamped, ignored 64b66b
// - E fixed one, ignored under 8b10b
// - 8b10b sends alignment parameters, 64b66b none
// - Transport parameters derived from mode code
// - Fixed alignment fields zero, versions one
// - Control bits field sent as zero
// - DID field carries programmed identifier
// - Each lane carries its mapped lane id
// - SCR field shows scrambler enable
// - Checksum is field sum modulo 256
// - M gives converter count for packing
// - N before, N' after control bits
// - F octets per frame, S samples per frame
// - Dual-channel cores sample own input once
//
// Chosen here: register access over AXI4-Lite and the register offsets.
module link_param_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic interleave_flag,
   output logic core_a_src,
   output logic core_b_src,
   output logic core_b_antiphase,
   output logic [5:0] lane_rate_x8,
   output logic ilas_enable,
   output logic [7:0] multiblocks_per_emb,
   output logic [7:0] eff_km1,
   output logic cal_busy
);
   // Software settings
   logic [4:0] mode_reg; // Selected link_mode_code
   logic [7:0] km1_reg; // Written frames_per_multiframe_minus_one
   logic [2:0] mux_reg; // Pending select and dual swap
   logic [2:0] mux_applied_reg; // Select in force since last calibration
   logic scr_reg; // Scrambler enable
   logic [7:0] did_reg; // Device identifier
   logic [7:0] lane_reg; // Lane index and octet index for readback
   logic [7:0] cal_cnt_reg; // Calibration cycles left
   // Bus state
   logic aw_full_reg, w_full_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic wstrb0_reg;
   logic bvalid_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   // Derived values
   converter_link_pkg::mode_params_t prm; // Parameters of current mode
   converter_link_pkg::mode_params_t wr_prm; // Parameters of a mode being written
   logic wr_do, wr_ok, wr_mapped, cal_start;
   logic [8:0] k_full, k_eff;
   logic [3:0] lid;
   localparam int ILAS_OCTETS_L = converter_link_pkg::ILAS_OCTETS; // Octets in one sequence
   logic [7:0] oct [ILAS_OCTETS_L];
   logic [7:0] chksum;
   logic [1:0] sel;

   // Current mode parameters
   mode_table cur_tbl (.code(mode_reg), .prm(prm));
   // Parameters of the code offered on the write channel
   mode_table wr_tbl (.code(wdata_reg[4:0]), .prm(wr_prm));

   // Address decode of the writable registers, used by writes only; reads decode in their own case
   function automatic logic is_rw_reg(input logic [7:0] a);
      is_rw_reg = (a == converter_link_pkg::REG_MODE) || (a == converter_link_pkg::REG_KM1)
         || (a == converter_link_pkg::REG_MUX) || (a == converter_link_pkg::REG_CTRL)
         || (a == converter_link_pkg::REG_DID) || (a == converter_link_pkg::REG_LANE);
   endfunction

   // Write channel readies: one write at a time
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready = !w_full_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Write commits once both address and data are held
   assign wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_mapped = is_rw_reg(awaddr_reg);
   // Reserved mode codes are refused and leave the mode alone
   assign wr_ok = wr_mapped && ((awaddr_reg != converter_link_pkg::REG_MODE) || wr_prm.valid);
   assign cal_start = wr_do && wr_ok && wstrb0_reg && (awaddr_reg == converter_link_pkg::REG_CTRL)
      && wdata_reg[converter_link_pkg::CTRL_CAL_BIT] && (cal_cnt_reg == 8'h00);

   // Address and data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb0_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_full_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
         end else if (wr_do) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= converter_link_pkg::RESP_OKAY;
      end else if (wr_do) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_ok ? converter_link_pkg::RESP_OKAY : converter_link_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Settings registers; only byte lane 0 carries fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= converter_link_pkg::MODE_RST;
         km1_reg <= converter_link_pkg::KM1_RST;
         mux_reg <= converter_link_pkg::MUX_RST;
         scr_reg <= converter_link_pkg::SCR_RST;
         did_reg <= converter_link_pkg::DID_RST;
         lane_reg <= converter_link_pkg::LANE_RST;
      end else if (wr_do && wr_ok && wstrb0_reg) begin
         unique case (awaddr_reg)
            converter_link_pkg::REG_MODE: mode_reg <= wdata_reg[4:0];
            converter_link_pkg::REG_KM1: km1_reg <= wdata_reg[7:0];
            converter_link_pkg::REG_MUX: mux_reg <= wdata_reg[2:0];
            converter_link_pkg::REG_CTRL: scr_reg <= wdata_reg[converter_link_pkg::CTRL_SCR_BIT];
            converter_link_pkg::REG_DID: did_reg <= wdata_reg[7:0];
            converter_link_pkg::REG_LANE: lane_reg <= wdata_reg[7:0];
            default: ;
         endcase
      end
   end

   // Calibration: the new input selection is applied only when it ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_cnt_reg <= 8'h00;
         mux_applied_reg <= converter_link_pkg::MUX_RST;
      end else if (cal_start) begin
         cal_cnt_reg <= 8'(converter_link_pkg::CAL_CYCLES);
      end else if (cal_cnt_reg != 8'h00) begin
         cal_cnt_reg <= cal_cnt_reg - 8'h01;
         if (cal_cnt_reg == 8'h01) begin
            mux_applied_reg <= mux_reg;
         end
      end
   end
   assign cal_busy = (cal_cnt_reg != 8'h00);

   // Core input routing from the applied selection
   assign sel = mux_applied_reg[1:0];
   assign interleave_flag = prm.des;
   always_comb begin
      if (prm.des) begin
         // Interleaved: both cores on one input, or each on its own in antiphase
         core_b_antiphase = 1'b1;
         if (sel == converter_link_pkg::SEL_A) begin
            core_a_src = converter_link_pkg::SRC_A;
            core_b_src = converter_link_pkg::SRC_A;
         end else if (sel == converter_link_pkg::SEL_B) begin
            core_a_src = converter_link_pkg::SRC_B;
            core_b_src = converter_link_pkg::SRC_B;
         end else begin
            core_a_src = converter_link_pkg::SRC_A;
            core_b_src = converter_link_pkg::SRC_B;
         end
      end else begin
         // Dual channel: each core on its own input, optional swap
         core_b_antiphase = 1'b0;
         core_a_src = mux_applied_reg[converter_link_pkg::MUX_SWAP_BIT];
         core_b_src = !mux_applied_reg[converter_link_pkg::MUX_SWAP_BIT];
      end
   end

   // Link rate and coding; link format ignores the input routing
   assign lane_rate_x8 = prm.r8;
   assign ilas_enable = !prm.enc64;
   assign multiblocks_per_emb = prm.enc64 ? converter_link_pkg::E_VAL : 8'h00;

   // K clamped to mode minimum and step; unused under 64b66b
   always_comb begin
      k_full = {1'b0, km1_reg} + 9'h001;
      if (k_full < {3'h0, prm.kmin}) begin
         k_eff = {3'h0, prm.kmin};
      end else begin
         k_eff = k_full & ~((9'h001 << prm.kstep_log2) - 9'h001);
      end
      eff_km1 = prm.enc64 ? 8'h00 : 8'(k_eff - 9'h001);
   end

   // Lane id within its link; lane indices L and above belong to the second link
   assign lid = (lane_reg[3:0] >= prm.l) ? lane_reg[3:0] - prm.l : lane_reg[3:0];

   // Alignment-sequence octets, fields as encoded (minus-one forms)
   always_comb begin
      oct[0] = did_reg;
      oct[1] = 8'h00;
      oct[2] = {3'h0, 1'h0, lid};
      oct[3] = {scr_reg, 3'h0, 4'(prm.l - 4'h1)};
      oct[4] = {4'h0, 4'(prm.f - 4'h1)};
      oct[5] = eff_km1;
      oct[6] = {4'h0, 4'(prm.m - 4'h1)};
      oct[7] = {2'h0, 1'h0, 5'(prm.n - 5'h01)};
      oct[8] = {converter_link_pkg::SUBCLASSV_VAL, 5'(prm.np - 5'h01)};
      oct[9] = {converter_link_pkg::JESDV_VAL, 1'h0, 4'(prm.s - 4'h1)};
      oct[10] = 8'h00;
      oct[11] = 8'h00;
      oct[12] = 8'h00;
      oct[13] = chksum;
   end

   // Checksum over field values, recomputed combinationally
   always_comb begin
      chksum = did_reg + {4'h0, lid} + {7'h00, scr_reg} + {4'h0, 4'(prm.l - 4'h1)}
         + {4'h0, 4'(prm.f - 4'h1)} + eff_km1 + {4'h0, 4'(prm.m - 4'h1)}
         + {3'h0, 5'(prm.n - 5'h01)} + {5'h00, converter_link_pkg::SUBCLASSV_VAL}
         + {3'h0, 5'(prm.np - 5'h01)} + {5'h00, converter_link_pkg::JESDV_VAL}
         + {4'h0, 4'(prm.s - 4'h1)};
   end

   // Read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= converter_link_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= converter_link_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            converter_link_pkg::REG_MODE: rdata_reg <= {27'h0, mode_reg};
            converter_link_pkg::REG_KM1: rdata_reg <= {24'h0, km1_reg};
            converter_link_pkg::REG_MUX: rdata_reg <= {29'h0, mux_reg};
            converter_link_pkg::REG_CTRL: rdata_reg <= {31'h0, scr_reg};
            converter_link_pkg::REG_DID: rdata_reg <= {24'h0, did_reg};
            converter_link_pkg::REG_LANE: rdata_reg <= {24'h0, lane_reg};
            converter_link_pkg::REG_STATUS: rdata_reg <= {20'h0, cal_busy, mux_applied_reg,
               prm.enc64, prm.des, prm.r8};
            converter_link_pkg::REG_PARAMS: rdata_reg <= {3'h0, prm.hd, prm.cs, prm.np, prm.n,
               prm.s, prm.f, prm.m, prm.l};
            converter_link_pkg::REG_ILAS: rdata_reg <= {8'h0, eff_km1, chksum,
               (lane_reg[7:4] < 4'(ILAS_OCTETS_L)) ? oct[lane_reg[7:4]] : 8'h00};
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= converter_link_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Register bus and mode checks
   mode_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
      prm.valid) else $error("current mode code is reserved");
   mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_do && wstrb0_reg && awaddr_reg == converter_link_pkg::REG_MODE && wr_prm.valid
      |=> mode_reg == $past(wdata_reg[4:0]) && s_axi_bresp == converter_link_pkg::RESP_OKAY)
      else $error("mode write not applied");
   // Reserved codes must leave the mode alone and answer with an error
   mode_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_do && awaddr_reg == converter_link_pkg::REG_MODE && !wr_prm.valid
      |=> $stable(mode_reg) && s_axi_bresp == converter_link_pkg::RESP_SLVERR)
      else $error("reserved mode code accepted");
   // Input routing and calibration checks
   interleave_a: assert property (@(posedge aclk) disable iff (!aresetn)
      interleave_flag == (core_b_antiphase)) else $error("interleave flag mismatch");
   mux_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(cal_cnt_reg == 8'h01) |=> $stable(mux_applied_reg))
      else $error("input select changed without calibration");
   // Busy for the whole count of sixteen cycles, idle right after
   cal_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_start |=> cal_busy ##15 cal_busy ##1 !cal_busy)
      else $error("calibration length wrong");
   antiphase_a: assert property (@(posedge aclk) disable iff (!aresetn)
      interleave_flag && sel == converter_link_pkg::SEL_BOTH |-> core_b_antiphase
      && core_a_src != core_b_src) else $error("both-input interleave wrong");
   single_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      interleave_flag && sel == converter_link_pkg::SEL_A |-> !core_a_src && !core_b_src)
      else $error("interleave input not input_a");
   dual_own_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !interleave_flag |-> core_a_src != core_b_src && !core_b_antiphase)
      else $error("dual channel routing wrong");
   // Frame count checks
   k_clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !prm.enc64 |-> (9'({1'b0, eff_km1} + 9'h001) >= {3'h0, prm.kmin}))
      else $error("K below mode minimum");
   // Clamped K must also sit on the step of its mode
   k_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !prm.enc64 |-> ((9'({1'b0, eff_km1} + 9'h001) & ((9'h001 << prm.kstep_log2) - 9'h001))
      == 9'h000)) else $error("K off its mode step");
   // Alignment field checks
   fixed_oct_a: assert property (@(posedge aclk) disable iff (!aresetn)
      oct[1] == 8'h00 && oct[10] == 8'h00 && oct[9][7:5] == 3'h1 && oct[7][7:5] == 3'h0)
      else $error("fixed alignment fields wrong");
   field_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      oct[0] == did_reg && oct[3][7] == scr_reg && oct[13] == chksum)
      else $error("user alignment fields wrong");
   // Scenario coverage
   cal_cov: cover property (@(posedge aclk) disable iff (!aresetn) cal_start ##17 !cal_busy);
   both_cov: cover property (@(posedge aclk) disable iff (!aresetn)
      interleave_flag && sel == converter_link_pkg::SEL_BOTH);
   rej_cov: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bresp == converter_link_pkg::RESP_SLVERR);
   swap_cov: cover property (@(posedge aclk) disable iff (!aresetn)
      !interleave_flag && mux_applied_reg[converter_link_pkg::MUX_SWAP_BIT]);
endmodule // link_param_ctrl

// >>> design/converter_link_pkg.sv
package converter_link_pkg;
   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_KM1 = 8'h04;
   localparam logic [7:0] REG_MUX = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0C;
   localparam logic [7:0] REG_DID = 8'h10;
   localparam logic [7:0] REG_LANE = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_PARAMS = 8'h1C;
   localparam logic [7:0] REG_ILAS = 8'h20;

   // Reset values
   localparam logic [4:0] MODE_RST = 5'h00;
   localparam logic [7:0] KM1_RST = 8'h1F;
   localparam logic [2:0] MUX_RST = 3'h0;
   localparam logic [7:0] DID_RST = 8'h00;
   localparam logic [7:0] LANE_RST = 8'h00;
   localparam logic SCR_RST = 1'h0;

   // Field positions
   localparam int CTRL_SCR_BIT = 0;
   localparam int CTRL_CAL_BIT = 1;
   localparam int MUX_SWAP_BIT = 2;

   // Input selection codes
   localparam logic [1:0] SEL_A = 2'h0;
   localparam logic [1:0] SEL_B = 2'h1;
   localparam logic [1:0] SEL_BOTH = 2'h2;
   localparam logic SRC_A = 1'h0;
   localparam logic SRC_B = 1'h1;

   // Calibration time and its cycle count at 125 MHz
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CAL_TIME_NS = 128;
   localparam int CAL_CYCLES = (CAL_TIME_NS * 1000) / CLK_PERIOD_PS;

   // Fixed alignment-sequence fields
   localparam logic [2:0] JESDV_VAL = 3'h1;
   localparam logic [2:0] SUBCLASSV_VAL = 3'h1;
   localparam logic [7:0] E_VAL = 8'h01;
   localparam int ILAS_OCTETS = 14;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Derived link parameters of one mode
   typedef struct packed {
      logic valid;
      logic des;
      logic enc64;
      logic [4:0] n;
      logic [1:0] cs;
      logic [4:0] np;
      logic [3:0] l;
      logic [3:0] m;
      logic [3:0] f;
      logic [3:0] s;
      logic hd;
      logic [5:0] kmin;
      logic [2:0] kstep_log2;
      logic [5:0] r8;
   } mode_params_t;
endpackage

// >>> design/mode_table.sv
module mode_table (
   input wire logic [4:0] code,
   output converter_link_pkg::mode_params_t prm
);
   // Build one table row; r8 is R times eight
   function automatic converter_link_pkg::mode_params_t row(
      input logic des, input logic [4:0] n, input logic [1:0] cs, input logic [4:0] np,
      input logic [3:0] l, input logic [3:0] m, input logic [3:0] f, input logic [3:0] s,
      input logic hd, input logic [5:0] kmin, input logic [2:0] ksl, input logic [5:0] r8);
      row = '{1'h1, des, 1'h0, n, cs, np, l, m, f, s, hd, kmin, ksl, r8};
   endfunction

   // Mode code lookup; reserved codes come back invalid
   always_comb begin
      unique case (code)
         5'h00: prm = row(1'h1, 5'h0C, 2'h0, 5'h0C, 4'h4, 4'h4, 4'h8, 4'h5, 1'h0, 6'h04, 3'h1, 6'h20);
         5'h01: prm = row(1'h1, 5'h0C, 2'h0, 5'h0C, 4'h8, 4'h8, 4'h8, 4'h5, 1'h0, 6'h04, 3'h1, 6'h10);
         5'h02: prm = row(1'h0, 5'h0C, 2'h0, 5'h0C, 4'h4, 4'h4, 4'h8, 4'h5, 1'h0, 6'h04, 3'h1, 6'h20);
         5'h03: prm = row(1'h0, 5'h0C, 2'h0, 5'h0C, 4'h8, 4'h8, 4'h8, 4'h5, 1'h0, 6'h04, 3'h1, 6'h10);
         5'h05: prm = row(1'h1, 5'h08, 2'h0, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 1'h0, 6'h20, 3'h4, 6'h14);
         5'h06: prm = row(1'h1, 5'h08, 2'h0, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 1'h0, 6'h20, 3'h4, 6'h0A);
         5'h07: prm = row(1'h0, 5'h08, 2'h0, 5'h08, 4'h4, 4'h1, 4'h1, 4'h4, 1'h0, 6'h20, 3'h4, 6'h14);
         5'h08: prm = row(1'h0, 5'h08, 2'h0, 5'h08, 4'h8, 4'h1, 4'h1, 4'h8, 1'h0, 6'h20, 3'h4, 6'h0A);
         5'h0A: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 1'h0, 6'h10, 3'h3, 6'h28);
         5'h0B: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 1'h0, 6'h10, 3'h3, 6'h14);
         5'h0C: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h8, 4'h2, 4'h2, 4'h4, 1'h0, 6'h10, 3'h3, 6'h0A);
         5'h0D: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h1, 4'h2, 4'h4, 4'h1, 1'h0, 6'h08, 3'h2, 6'h28);
         5'h0E: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h2, 4'h2, 4'h2, 4'h1, 1'h0, 6'h10, 3'h3, 6'h14);
         5'h0F: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h4, 4'h2, 4'h2, 4'h2, 1'h0, 6'h10, 3'h3, 6'h0A);
         5'h10: prm = row(1'h0, 5'h0F, 2'h1, 5'h10, 4'h8, 4'h2, 4'h2, 4'h4, 1'h0, 6'h10, 3'h3, 6'h05);
         5'h13: prm = row(1'h1, 5'h0C, 2'h0, 5'h0C, 4'h6, 4'h1, 4'h2, 4'h8, 1'h1, 6'h10, 3'h3, 6'h14);
         5'h14: prm = row(1'h0, 5'h0C, 2'h0, 5'h0C, 4'h6, 4'h1, 4'h2, 4'h8, 1'h1, 6'h10, 3'h3, 6'h14);
         5'h15: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h2, 4'h1, 4'h2, 4'h2, 1'h0, 6'h10, 3'h3, 6'h28);
         5'h16: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h4, 4'h1, 4'h2, 4'h4, 1'h0, 6'h10, 3'h3, 6'h14);
         5'h17: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h1, 4'h1, 4'h2, 4'h1, 1'h0, 6'h10, 3'h3, 6'h28);
         5'h18: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h2, 4'h1, 4'h2, 4'h2, 1'h0, 6'h10, 3'h3, 6'h14);
         5'h19: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h8, 4'h1, 4'h2, 4'h8, 1'h0, 6'h10, 3'h3, 6'h0A);
         5'h1A: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h4, 4'h1, 4'h2, 4'h4, 1'h0, 6'h10, 3'h3, 6'h0A);
         5'h1B: prm = row(1'h1, 5'h0F, 2'h1, 5'h10, 4'h8, 4'h1, 4'h2, 4'h8, 1'h0, 6'h10, 3'h3, 6'h05);
         default: prm = '0;
      endcase
   end
endmodule // mode_table

// >>> verif/link_receiver_model.sv
module link_receiver_model (
   input wire logic aclk,
   input wire logic ilas_enable,
   input wire logic [7:0] multiblocks_per_emb,
   output logic expect_ilas
);
   timeunit 1ns;
   timeprecision 1ps;
   // Receiver waits for the alignment sequence only on an 8b/10b link
   always_ff @(posedge aclk) begin
      expect_ilas <= ilas_enable && (multiblocks_per_emb == 8'h00);
   end
endmodule // link_receiver_model

// >>> verif/converter_mode_and_lane_alignment_params_bench.sv
module converter_mode_and_lane_alignment_params_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic ilv, csa, csb, anti, ilas, cal, xil;
   logic [7:0] awa, ara, e, kmo;
   logic [31:0] wd, rd, d;
   logic [3:0] ws;
   logic [1:0] bresp, rresp, rp;
   logic [5:0] r8;
   int mismatches, num_checks, km, did;
   int md[7] = '{0, 2, 5, 8, 10, 16, 19};
   int ds[7] = '{1, 0, 1, 0, 0, 0, 1};
   int rx[7] = '{32, 32, 20, 10, 40, 5, 20};
   link_param_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .interleave_flag(ilv), .core_a_src(csa), .core_b_src(csb), .core_b_antiphase(anti),
      .lane_rate_x8(r8), .ilas_enable(ilas), .multiblocks_per_emb(e), .eff_km1(kmo),
      .cal_busy(cal));
   link_receiver_model rx_model (.aclk(aclk), .ilas_enable(ilas),
      .multiblocks_per_emb(e), .expect_ilas(xil));
   // Free-running 125 MHz clock
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   // Compare seen against expected
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Write one word; handshakes judged on settled values, released after the edge
   // No wait limit of its own: only the watchdog ends a hung transfer
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      logic ha, hw, hb;
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(negedge aclk);
         ha = awv && awr;
         hw = wv && wr;
         hb = bv;
         r = bresp;
         @(posedge aclk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
      end while (!hb);
      // One idle edge so the next call never re-raises bready in this step
      br <= 1'b0;
      @(posedge aclk);
   endtask
   // Read one word; data taken with the edge that sees rvalid
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      logic ha, hr;
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(negedge aclk);
         ha = arv && arr;
         hr = rv;
         v = rd;
         r = rresp;
         @(posedge aclk);
         if (ha) arv <= 1'b0;
      end while (!hr);
      rr <= 1'b0;
      @(posedge aclk);
   endtask
   // Start calibration and wait for it to finish
   task automatic calib();
      wr_reg(8'h0C, 32'h2, rp);
      chk(cal, 1'b1);
      while (cal !== 1'b0) begin
         @(negedge aclk);
      end
      @(posedge aclk);
   endtask
   // Effective K-1 for a 4:2 mode
   function automatic logic [7:0] keff(input int k1);
      int k;
      k = k1 + 1;
      if (k < 4) k = 4;
      else k = k - (k % 2);
      return 8'(k - 1);
   endfunction
   // Checksum in mode 0: fixed fields add 41
   function automatic logic [7:0] cks(input int dv, input int lid, input int s, input int k1);
      return 8'(dv + lid + s + k1 + 41);
   endfunction
   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #40000;
      mismatches++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {awv, wv, br, arv, rr} = 0;
      awa = 0; ara = 0; wd = 0; aresetn = 0;
      ws = 4'hF;
      void'($urandom(24149));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd_reg(8'h04, d, rp);
      chk(d, 32'h1F);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         wr_reg(8'h00, md[i], rp);
         chk(rp, 2'h0);
         chk(ilv, ds[i]);
         chk(r8, rx[i]);
         chk(xil, 1'b1);
         chk(e, 8'h00);
      end
      wr_reg(8'h00, 32'h4, rp);
      chk(rp, 2'h2);
      rd_reg(8'h00, d, rp);
      chk(d, 32'd19);
      $display("test modes done");
      wr_reg(8'h00, 32'h0, rp);
      for (int i = 0; i < 8; i++) begin
         km = (i == 0) ? 0 : (i == 1) ? 2 : (i == 2) ? 255 : $urandom % 256;
         wr_reg(8'h04, km, rp);
         chk(kmo, keff(km));
      end
      // Byte lane 0 off: the field must keep its value
      ws <= 4'h0;
      wr_reg(8'h04, 32'h0, rp);
      ws <= 4'hF;
      chk(kmo, keff(km));
      $display("test k done");
      wr_reg(8'h08, 32'h1, rp);
      chk(csa, 1'b0);
      calib();
      chk(csa, 1'b1);
      wr_reg(8'h08, 32'h2, rp);
      calib();
      chk({csa, csb, anti}, 3'b011);
      wr_reg(8'h00, 32'h2, rp);
      chk({ilv, anti}, 2'b00);
      chk({csa, csb}, 2'b01);
      // Dual mode with the inputs swapped
      wr_reg(8'h08, 32'h4, rp);
      calib();
      chk({csa, csb}, 2'b10);
      $display("test mux done");
      wr_reg(8'h00, 32'h0, rp);
      // Mode 0 table row and its alignment octets 7 and 9
      rd_reg(8'h1C, d, rp);
      chk(d, 32'h018C_5844);
      wr_reg(8'h14, 32'h70, rp);
      rd_reg(8'h20, d, rp);
      chk(d[7:0], 8'h0B);
      wr_reg(8'h14, 32'h90, rp);
      rd_reg(8'h20, d, rp);
      chk(d[7:0], 8'h24);
      for (int j = 0; j < 2; j++) begin
         km = $urandom % 256;
         did = $urandom % 256;
         wr_reg(8'h04, km, rp);
         wr_reg(8'h10, did, rp);
         wr_reg(8'h0C, j, rp);
         wr_reg(8'h14, j ? 5 : 2, rp);
         rd_reg(8'h20, d, rp);
         chk(d[15:8], cks(did, j ? 1 : 2, j, keff(km)));
         chk(d[23:16], keff(km));
         chk(d[7:0], did);
      end
      rd_reg(8'h40, d, rp);
      chk(rp, 2'h2);
      $display("test checksum done");
      print_verdict();
   end
endmodule // converter_mode_and_lane_alignment_params_bench
